// >>> shared/tsr_pkg.sv
// constants, register map and reset values of the sensor register bank
package tsr_pkg;
    localparam int BYTE_W = 8;
    localparam int TEMP_W = 16;
    localparam int NUM_FLAGS = 3;
    localparam int NUM_SETPT = 7;
    localparam int FLAG_LOW = 0;
    localparam int FLAG_HIGH = 1;
    localparam int FLAG_CRIT = 2;
    localparam int LOW_FLAG_BITS = 3;
    localparam int HYST_SHIFT = 7;
    localparam int SETUP_RES16_BIT = 7;
    localparam int SETUP_MODE_LSB = 5;
    localparam int SETUP_MODE_MSB = 6;

    localparam logic [7:0] ADDR_READ_HI = 8'h00;
    localparam logic [7:0] ADDR_READ_LO = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_SETUP = 8'h03;
    localparam logic [7:0] ADDR_UPPER_HI = 8'h04;
    localparam logic [7:0] ADDR_UPPER_LO = 8'h05;
    localparam logic [7:0] ADDR_LOWER_HI = 8'h06;
    localparam logic [7:0] ADDR_LOWER_LO = 8'h07;
    localparam logic [7:0] ADDR_CRIT_HI = 8'h08;
    localparam logic [7:0] ADDR_CRIT_LO = 8'h09;
    localparam logic [7:0] ADDR_HYST = 8'h0a;
    localparam logic [7:0] ADDR_IDENT = 8'h0b;
    localparam logic [7:0] ADDR_RSVD_A = 8'h0c;
    localparam logic [7:0] ADDR_RSVD_B = 8'h0d;
    localparam logic [7:0] ADDR_RSVD_C = 8'h2e;
    localparam logic [7:0] ADDR_RESTART = 8'h2f;

    localparam logic [7:0] RST_POINTER = 8'h00;
    localparam logic [7:0] RST_SETUP = 8'h00;
    localparam logic [15:0] RST_READING = 16'h0000;
    localparam logic [7:0] SETPT_RST [NUM_SETPT] = '{
        8'h20, 8'h00, 8'h05, 8'h00, 8'h49, 8'h80, 8'h05};
    localparam logic [3:0] STAT_UNUSED = 4'h0;
    localparam logic [7:0] RSVD_READ = 8'h00;

    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_ONE_SPS = 2'h2;
endpackage

// >>> shared/tsr_cmp_if.sv
// signals between the register bank and the limit comparator
`timescale 1ns/1ps
interface tsr_cmp_if;
    logic signed [15:0] temp;
    logic signed [15:0] upper;
    logic signed [15:0] lower;
    logic signed [15:0] crit;
    logic [7:0] hyst;
    logic [2:0] cond;
    logic [2:0] ok;
    modport bank (output temp, upper, lower, crit, hyst, input cond, ok);
    modport cmp (input temp, upper, lower, crit, hyst, output cond, ok);
endinterface

// >>> core/tsr_limit_cmp.sv
// compares a fresh result against the limits, with hysteresis
`timescale 1ns/1ps
module tsr_limit_cmp #(
    parameter int HYST_W = 4
) (
    tsr_cmp_if.cmp cif
);
    import tsr_pkg::*;

    if (HYST_W < 1 || HYST_W > BYTE_W) begin : g_bad_hyst
        $error("hysteresis width out of range");
    end

    wire signed [16:0] t = {cif.temp[15], cif.temp};
    wire signed [16:0] lo = {cif.lower[15], cif.lower};
    wire signed [16:0] hi = {cif.upper[15], cif.upper};
    wire signed [16:0] cr = {cif.crit[15], cif.crit};
    // hysteresis is in whole degrees, limits in 1/128 degree
    wire signed [16:0] h =
        signed'(17'(cif.hyst[HYST_W-1:0]) << HYST_SHIFT);

    ///////////////////////////////////////////////////////////////////////
    assign cif.cond[FLAG_LOW] = t < lo;
    assign cif.cond[FLAG_HIGH] = t > hi;
    assign cif.cond[FLAG_CRIT] = t > cr;
    assign cif.ok[FLAG_LOW] = t >= lo + h;
    assign cif.ok[FLAG_HIGH] = t <= hi - h;
    assign cif.ok[FLAG_CRIT] = t <= cr - h;
endmodule

// >>> core/tsr_regmap.sv
// register bank and address pointer of the temperature sensor
`timescale 1ns/1ps
module tsr_regmap #(
    parameter logic [7:0] ID_CODE = 8'h5a, // value is arbitrary
    parameter int HYST_W = 4
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic lk_first,
    input wire logic lk_wr,
    input wire logic lk_rd,
    input wire logic [tsr_pkg::BYTE_W-1:0] lk_wdata,
    input wire logic conv_valid,
    input wire logic [tsr_pkg::TEMP_W-1:0] conv_data,
    output logic [tsr_pkg::BYTE_W-1:0] rd_data,
    output logic rd_valid,
    output logic [tsr_pkg::BYTE_W-1:0] setup_byte,
    output logic mode_written,
    output logic soft_restart,
    output logic [tsr_pkg::NUM_FLAGS-1:0] alarm_flags
);
    import tsr_pkg::*;

    localparam int LK_W = BYTE_W + 4;
    localparam int LK_CLK = LK_W - 1;
    localparam int LK_FIRST = LK_W - 2;
    localparam int LK_WR = LK_W - 3;
    localparam int LK_RD = LK_W - 4;

    if (HYST_W < 1 || HYST_W > BYTE_W) begin : g_bad_hyst_w
        $error("hysteresis width out of range");
    end

    ///////////////////////////////////////////////////////////////////////
    // link sampling: two stages, then edge detect on the second
    logic [LK_W-1:0] lk_meta_r;
    logic [LK_W-1:0] lk_sync_r;
    logic lk_clk_prev_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lk_meta_r <= '0;
            lk_sync_r <= '0;
            lk_clk_prev_r <= 1'b0;
        end else if (ce) begin
            lk_meta_r <= {link_clk, lk_first, lk_wr, lk_rd, lk_wdata};
            lk_sync_r <= lk_meta_r;
            lk_clk_prev_r <= lk_sync_r[LK_CLK];
        end
    end

    wire lk_rise = ce & lk_sync_r[LK_CLK] & ~lk_clk_prev_r;
    wire take_wr = lk_rise & lk_sync_r[LK_WR];
    wire take_rd = lk_rise & lk_sync_r[LK_RD];
    wire [BYTE_W-1:0] wdata = lk_sync_r[BYTE_W-1:0];

    ///////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] pointer_r;
    logic [7:0] setup_r;
    logic [15:0] reading_r;
    logic [7:0] setpt_r [NUM_SETPT];
    logic [NUM_FLAGS-1:0] flag_r;
    logic rdy_n_r;
    logic restart_r;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    logic mode_written_r;

    // a restart write acts like power-up one cycle later
    wire clr = reset | restart_r;

    ///////////////////////////////////////////////////////////////////////
    // decode
    wire ptr_load = take_wr & lk_sync_r[LK_FIRST];
    wire reg_wr = take_wr & ~lk_sync_r[LK_FIRST];
    wire at_read_hi = pointer_r == ADDR_READ_HI;
    wire at_read_lo = pointer_r == ADDR_READ_LO;
    wire at_status = pointer_r == ADDR_STATUS;
    wire at_setup = pointer_r == ADDR_SETUP;
    wire at_ident = pointer_r == ADDR_IDENT;
    wire at_restart = pointer_r == ADDR_RESTART;
    wire at_setpt = pointer_r >= ADDR_UPPER_HI && pointer_r <= ADDR_HYST;
    wire [2:0] setpt_idx = 3'(pointer_r - ADDR_UPPER_HI);

    // only setup, setpoints and restart take data; others are ignored
    wire wr_setup = reg_wr & at_setup;
    wire wr_restart = reg_wr & at_restart;
    wire rd_result = take_rd & (at_read_hi | at_read_lo);
    wire rd_status = take_rd & at_status;
    wire conv_take = ce & conv_valid;

    wire res16 = setup_r[SETUP_RES16_BIT];
    wire [1:0] new_mode = wdata[SETUP_MODE_MSB:SETUP_MODE_LSB];
    wire mode_rearm = wr_setup &
        (new_mode == MODE_ONE_SHOT || new_mode == MODE_ONE_SPS);

    ///////////////////////////////////////////////////////////////////////
    // limit comparison on the incoming result
    tsr_cmp_if cif ();

    assign cif.temp = res16 ? conv_data
        : {conv_data[TEMP_W-1:LOW_FLAG_BITS], {LOW_FLAG_BITS{1'b0}}};
    assign cif.upper = {setpt_r[0], setpt_r[1]};
    assign cif.lower = {setpt_r[2], setpt_r[3]};
    assign cif.crit = {setpt_r[4], setpt_r[5]};
    assign cif.hyst = setpt_r[6];

    tsr_limit_cmp #(
        .HYST_W(HYST_W)
    ) u_cmp (
        .cif(cif.cmp)
    );

    ///////////////////////////////////////////////////////////////////////
    // pointer and restart
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            pointer_r <= RST_POINTER;
        end else if (ce) begin
            if (ptr_load) begin
                pointer_r <= wdata;
            end else if (take_rd && at_read_hi) begin
                pointer_r <= ADDR_READ_LO;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            restart_r <= 1'b0;
        end else if (ce) begin
            restart_r <= wr_restart;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // setup and setpoint bytes
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            setup_r <= RST_SETUP;
        end else if (ce && wr_setup) begin
            setup_r <= wdata;
        end
    end

    for (genvar i = 0; i < NUM_SETPT; i++) begin : g_setpt
        wire wr_this = reg_wr & at_setpt & setpt_idx == 3'(i);
        always_ff @(posedge ref_clk) begin
            if (clr) begin
                setpt_r[i] <= SETPT_RST[i];
            end else if (ce && wr_this) begin
                setpt_r[i] <= wdata;
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // conversion result; no write path from the link
    wire [LOW_FLAG_BITS-1:0] low_bits = res16
        ? conv_data[LOW_FLAG_BITS-1:0]
        : cif.cond;

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            reading_r <= RST_READING;
        end else if (conv_take) begin
            // sign and upper bits kept as delivered
            reading_r <= {conv_data[TEMP_W-1:LOW_FLAG_BITS], low_bits};
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // status flags: a new event wins over a clear in the same cycle
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        wire set = conv_take & cif.cond[i];
        wire drop = rd_status | (conv_take & cif.ok[i]);
        always_ff @(posedge ref_clk) begin
            if (clr) begin
                flag_r[i] <= 1'b0;
            end else if (set) begin
                flag_r[i] <= 1'b1;
            end else if (ce && drop) begin
                flag_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            rdy_n_r <= 1'b1;
        end else if (conv_take) begin
            rdy_n_r <= 1'b0;
        end else if (ce && (rd_result || mode_rearm)) begin
            rdy_n_r <= 1'b1;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // read selection
    wire [7:0] status_byte = {rdy_n_r, flag_r, STAT_UNUSED};
    wire [7:0] rd_mux =
        at_read_hi ? reading_r[15:8] :
        at_read_lo ? reading_r[7:0] :
        at_status ? status_byte :
        at_setup ? setup_r :
        at_setpt ? setpt_r[setpt_idx] :
        at_ident ? ID_CODE :
        RSVD_READ;

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            rd_data_r <= RSVD_READ;
            rd_valid_r <= 1'b0;
            mode_written_r <= 1'b0;
        end else if (ce) begin
            if (take_rd) begin
                rd_data_r <= rd_mux;
            end
            rd_valid_r <= take_rd;
            mode_written_r <= wr_setup;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign setup_byte = setup_r;
    assign mode_written = mode_written_r;
    assign soft_restart = restart_r;
    assign alarm_flags = flag_r;

    ///////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset || restart_r || !ce);

    sequence s_read_hi;
        take_rd && at_read_hi;
    endsequence

    sequence s_conv;
        conv_take;
    endsequence

    sequence s_status_read;
        rd_status && !conv_take;
    endsequence

    a_ptr_reset_zero: assert property (
        $fell(reset) |-> pointer_r == RST_POINTER)
        else $error("pointer not zero after reset");

    a_ptr_auto_adv: assert property (
        s_read_hi ##1 !ptr_load |-> pointer_r == ADDR_READ_LO)
        else $error("pointer did not advance after high byte");

    a_read_answer: assert property (
        s_read_hi |=> rd_valid && rd_data == $past(reading_r[15:8])
        ##1 !rd_valid || rd_data == reading_r[7:0])
        else $error("high byte read answer wrong");

    a_reading_ro: assert property (
        reg_wr && (at_read_hi || at_read_lo) && !conv_take
        |=> reading_r == $past(reading_r))
        else $error("result changed by a link write");

    a_ro_no_store: assert property (
        reg_wr && (at_status || at_ident || at_read_lo)
        |=> setup_r == $past(setup_r) && $stable(setpt_r[0]))
        else $error("read-only write changed setup");

    a_flag_13bit: assert property (
        s_conv ##0 !res16 |=> reading_r[2:0] == $past(cif.cond))
        else $error("alarm flags not in result low bits");

    a_lsb_16bit: assert property (
        s_conv ##0 res16 |=> reading_r[2:0] == $past(conv_data[2:0]))
        else $error("low temperature bits not kept");

    a_rdy_on_conv: assert property (
        s_conv |=> !rdy_n_r ##1 (!rdy_n_r || $past(rd_result || mode_rearm)))
        else $error("ready bit not low after result");

    a_rdy_on_read: assert property (
        rd_result && !conv_take |=> rdy_n_r)
        else $error("ready bit not returned on result read");

    a_rdy_on_mode: assert property (
        mode_rearm && !conv_take |=> rdy_n_r && mode_written)
        else $error("ready bit not returned on mode write");

    a_status_clear: assert property (
        s_status_read |=> flag_r == '0 ##0 rd_data[6:4] == $past(flag_r))
        else $error("status read did not clear flags");

    a_status_zero: assert property (
        rd_status |=> rd_data[3:0] == STAT_UNUSED)
        else $error("unused status bits not zero");

    a_flag_set: assert property (
        conv_take && cif.cond[FLAG_CRIT] |=> alarm_flags[FLAG_CRIT])
        else $error("critical flag not set");

    a_hi_byte_sign: assert property (
        s_conv |=> reading_r[15:8] == $past(conv_data[15:8]))
        else $error("result high byte not as delivered");

    a_lo_byte_temp: assert property (
        s_conv |=> reading_r[7:3] == $past(conv_data[7:3]))
        else $error("result low byte bits not as delivered");

    a_ptr_load: assert property (
        ptr_load |=> pointer_r == $past(wdata))
        else $error("pointer byte not loaded");

    a_setup_store: assert property (
        wr_setup |=> setup_byte == $past(wdata))
        else $error("setup byte not stored");

    a_hyst_store: assert property (
        reg_wr && pointer_r == ADDR_HYST |=> cif.hyst == $past(wdata))
        else $error("hysteresis byte not stored");

    a_flag_low_set: assert property (
        conv_take && cif.cond[FLAG_LOW] |=> alarm_flags[FLAG_LOW])
        else $error("low flag not set");

    a_flag_high_set: assert property (
        conv_take && cif.cond[FLAG_HIGH] |=> alarm_flags[FLAG_HIGH])
        else $error("high flag not set");

    a_flag_hold: assert property (
        !conv_take && !rd_status |=> $stable(flag_r))
        else $error("flags changed without a cause");

    a_ready_hold: assert property (
        !conv_take && !rd_result && !mode_rearm |=> $stable(rdy_n_r))
        else $error("ready bit changed without a cause");
endmodule

// >>> sim/tsr_host_model.sv
// serial host model that drives the link side of the register bank
`timescale 1ns/1ps
module tsr_host_model (
    output logic link_clk,
    output logic lk_first,
    output logic lk_wr,
    output logic lk_rd,
    output logic [7:0] lk_wdata
);
    initial begin
        link_clk = 1'b0;
        lk_first = 1'b0;
        lk_wr = 1'b0;
        lk_rd = 1'b0;
        lk_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // one byte per link clock; the clock stands low between bytes
    // signals change 32 ns away from the rise on both sides
    task automatic xfer(input logic f, input logic w, input logic r,
                        input logic [7:0] d);
        lk_first = f;
        lk_wr = w;
        lk_rd = r;
        lk_wdata = d;
        #32;
        link_clk = 1'b1;
        #32;
        link_clk = 1'b0;
        lk_first = 1'b0;
        lk_wr = 1'b0;
        lk_rd = 1'b0;
        // released data shows the inverse, not a stale copy
        lk_wdata = ~d;
        #32;
    endtask
endmodule

// >>> sim/tb.sv
// self-checking bench of the sensor register bank
`timescale 1ns/1ps
module tb;
    import tsr_pkg::*;
    // identity value is arbitrary
    localparam logic [7:0] ID_VAL = 8'h3c;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic conv_valid = 1'b0;
    logic [15:0] conv_data = 16'h0000;
    logic link_clk, lk_first, lk_wr, lk_rd;
    logic [7:0] lk_wdata, rd_data, setup_byte, rd_got;
    logic rd_valid, mode_written, soft_restart;
    logic [2:0] alarm_flags;
    int errors = 0;
    int cmp_count = 0;
    int rd_cnt = 0;
    int mw_cnt = 0;
    int sr_cnt = 0;
    logic [7:0] rst_tab [7] = '{8'h20, 8'h00, 8'h05, 8'h00, 8'h49, 8'h80,
                               8'h05};
    logic [7:0] mode_tab [4] = '{8'h00, 8'h20, 8'h40, 8'h60};
    logic [7:0] rdy_tab [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
    logic [7:0] ro_adr [6] = '{8'h00, 8'h01, 8'h0b, 8'h0c, 8'h0d, 8'h2e};
    logic [7:0] ro_exp [6] = '{8'h12, 8'h30, ID_VAL, 8'h00, 8'h00, 8'h00};

    always #2.5 ref_clk = ~ref_clk;

    tsr_host_model i_host (.link_clk(link_clk), .lk_first(lk_first),
        .lk_wr(lk_wr), .lk_rd(lk_rd), .lk_wdata(lk_wdata));

    tsr_regmap #(.ID_CODE(ID_VAL), .HYST_W(4)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .ce(ce), .link_clk(link_clk),
        .lk_first(lk_first), .lk_wr(lk_wr), .lk_rd(lk_rd),
        .lk_wdata(lk_wdata), .conv_valid(conv_valid),
        .conv_data(conv_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .setup_byte(setup_byte), .mode_written(mode_written),
        .soft_restart(soft_restart), .alarm_flags(alarm_flags));

    always @(posedge ref_clk) begin
        if (rd_valid === 1'b1) begin
            rd_got <= rd_data;
            rd_cnt <= rd_cnt + 1;
        end
        if (mode_written === 1'b1) mw_cnt <= mw_cnt + 1;
        if (soft_restart === 1'b1) sr_cnt <= sr_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conv(input logic [15:0] d);
        @(negedge ref_clk);
        conv_valid = 1'b1;
        conv_data = d;
        @(negedge ref_clk);
        conv_valid = 1'b0;
        conv_data = ~d;
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, 1'b1, 1'b0, a);
        i_host.xfer(1'b0, 1'b1, 1'b0, d);
    endtask

    task automatic rd_ptr(input logic [7:0] exp);
        int n;
        n = rd_cnt;
        i_host.xfer(1'b0, 1'b0, 1'b1, 8'h00);
        chk(16'(rd_cnt), 16'(n + 1));
        chk({8'h00, rd_got}, {8'h00, exp});
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        i_host.xfer(1'b1, 1'b1, 1'b0, a);
        rd_ptr(exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        chk(setup_byte, 8'h00);
        chk(alarm_flags, 3'b000);
        conv(16'h1234);
        rd_ptr(8'h12);
        rd_ptr(8'h30);
        rd_reg(ADDR_STATUS, 8'h80);
        conv(16'h1234);
        rd_reg(ADDR_STATUS, 8'h00);
    endtask

    task automatic t_alarms();
        conv(16'h0100);
        chk(alarm_flags, 3'b001);
        rd_reg(ADDR_READ_HI, 8'h01);
        rd_ptr(8'h01);
        rd_reg(ADDR_STATUS, 8'h90);
        chk(alarm_flags, 3'b000);
        rd_ptr(8'h80);
        conv(16'h4a00);
        chk(alarm_flags, 3'b110);
        rd_reg(ADDR_READ_LO, 8'h06);
        rd_reg(ADDR_STATUS, 8'he0);
        conv(16'h4a00);
        conv(16'h1e00);
        chk(alarm_flags, 3'b010);
        conv(16'h1234);
        chk(alarm_flags, 3'b000);
        rd_reg(ADDR_STATUS, 8'h00);
    endtask

    task automatic t_res16();
        wr_reg(ADDR_SETUP, 8'h80);
        chk(setup_byte, 8'h80);
        conv(16'h0107);
        rd_reg(ADDR_READ_HI, 8'h01);
        rd_ptr(8'h07);
    endtask

    task automatic t_modes();
        int n;
        n = mw_cnt;
        for (int i = 0; i < 4; i++) begin
            conv(16'h1234);
            wr_reg(ADDR_SETUP, mode_tab[i]);
            chk(setup_byte, mode_tab[i]);
            rd_reg(ADDR_STATUS, rdy_tab[i]);
        end
        chk(16'(mw_cnt), 16'(n + 4));
    endtask

    task automatic t_read_only();
        for (int i = 0; i < 6; i++) begin
            wr_reg(ro_adr[i], 8'ha5);
            rd_reg(ro_adr[i], ro_exp[i]);
        end
        rd_reg(ADDR_RESTART, 8'h00);
        rd_reg(8'h40, 8'h00);
        wr_reg(ADDR_UPPER_HI, 8'h33);
        rd_reg(ADDR_UPPER_HI, 8'h33);
        wr_reg(ADDR_HYST, 8'hff);
        rd_reg(ADDR_HYST, 8'hff);
    endtask

    task automatic t_restart();
        int n;
        n = sr_cnt;
        wr_reg(ADDR_RESTART, 8'h00);
        chk(16'(sr_cnt), 16'(n + 1));
        chk(setup_byte, 8'h00);
        rd_ptr(8'h00);
        rd_ptr(8'h00);
        for (int i = 0; i < 7; i++) begin
            rd_reg(8'(i + 4), rst_tab[i]);
        end
        rd_reg(ADDR_STATUS, 8'h80);
    endtask

    task automatic t_freeze();
        @(negedge ref_clk);
        ce = 1'b0;
        conv(16'h4a00);
        i_host.xfer(1'b1, 1'b1, 1'b0, ADDR_SETUP);
        @(negedge ref_clk);
        ce = 1'b1;
        chk(alarm_flags, 3'b000);
        rd_ptr(8'h80);
    endtask

    task automatic t_hard_reset();
        wr_reg(ADDR_SETUP, 8'h80);
        conv(16'h4a00);
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        chk(setup_byte, 8'h00);
        chk(alarm_flags, 3'b000);
        rd_ptr(8'h00);
        rd_ptr(8'h00);
        rd_reg(ADDR_STATUS, 8'h80);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_power_up();
        t_alarms();
        t_res16();
        t_modes();
        t_read_only();
        t_restart();
        t_freeze();
        t_hard_reset();
        report_and_stop();
    end
endmodule
